// file: rtl/lcd_row_driver_shift_latch.v
// lcd row/column driver: shift register, output latch and level selector
`include "lcd_row_driver_map.vh"
`default_nettype none
module lcd_row_driver_shift_latch (
  // clock and reset
  input wire i_clock,
  input wire i_reset_n,
  // controller clocks and controls
  input wire i_data_shift_clock_in,
  input wire i_row_latch_clock_in,
  input wire i_frame_alternate,
  input wire i_display_blank_n,
  input wire i_role_select,
  input wire i_interface_mode_select,
  input wire i_shift_direction,
  // data pins: bit0 serial/d1, bit1 left, bit2 middle, bit3 right
  input wire [3:0] i_data,
  output wire [3:0] o_data,
  output wire [3:0] o_data_oe,
  // cascade enable pins
  input wire i_enable_left_n,
  output wire o_enable_left_n,
  output wire o_enable_left_oe,
  input wire i_enable_right_n,
  output wire o_enable_right_n,
  output wire o_enable_right_oe,
  // driver outputs, two-bit level code per output
  output wire [159:0] o_driver_outputs
);
  // every pin is filtered; an edge shows four clocks after the pin moves
  wire [`SYNC_WIDTH-1:0] sync_w;
  pin_sync #(
    .W(`SYNC_WIDTH)
  ) u_sync (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_async({i_enable_right_n, i_enable_left_n, i_data, i_shift_direction,
      i_interface_mode_select, i_role_select, i_display_blank_n,
      i_frame_alternate, i_row_latch_clock_in, i_data_shift_clock_in}),
    .o_level(sync_w)
  );
  wire dsc_w = sync_w[0];
  wire rlc_w = sync_w[1];
  wire alt_w = sync_w[2];
  wire blank_n_w = sync_w[3];
  wire role_w = sync_w[4];
  wire mode_w = sync_w[5];
  wire dir_w = sync_w[6];
  // data pins are sampled on the same clock as the edge detect
  wire [3:0] din_w = sync_w[10:7];
  wire enl_n_w = sync_w[11];
  wire enr_n_w = sync_w[12];

  reg dsc_prev_r;
  reg rlc_prev_r;
  reg [79:0] seg_r;
  reg [79:0] latch_r;
  reg [6:0] count_r;
  reg done_r;
  reg [3:0] dout_r;

  wire dsc_fall = dsc_prev_r & ~dsc_w;
  wire rlc_fall = rlc_prev_r & ~rlc_w;
  // role and mode decode from the filtered pins
  wire is_seg = (role_w == `ROLE_SEG);
  wire is_serial = is_seg & (mode_w == `MODE_SER_OR_DUAL);
  wire is_dual = ~is_seg & (mode_w == `MODE_SER_OR_DUAL);
  // enable enters on the upstream side of the shift direction
  wire enable_in_n = dir_w ? enr_n_w : enl_n_w;
  wire [6:0] fill_count = is_serial ? `SEG_BITS : `SEG_NIBBLES;
  // shifting allowed only while enabled and not yet full
  wire seg_active = is_seg & ~enable_in_n & ~done_r & ~rlc_w;

  // level code for one output
  function [1:0] level_sel;
    input m;
    input d;
    input com;
    input bl_n;
    begin
      if (!bl_n) begin
        level_sel = `LVL_V0;
      end else if (d) begin
        level_sel = (m ^ com) ? `LVL_V5 : `LVL_V0;
      end else begin
        level_sel = m ? `LVL_V43 : `LVL_V12;
      end
    end
  endfunction

  // one shift step of the segment register
  function [79:0] seg_shift;
    input [79:0] s;
    input [3:0] d;
    input ser;
    input rev;
    begin
      if (ser && !rev) begin
        seg_shift = {s[78:0], d[0]};
      end else if (ser) begin
        seg_shift = {d[0], s[79:1]};
      end else if (!rev) begin
        seg_shift = {s[75:0], d};
      end else begin
        seg_shift = {d, s[79:4]};
      end
    end
  endfunction

  // one latch clock step of the common scan register
  function [79:0] com_shift;
    input [79:0] l;
    input [3:0] d;
    input dual;
    input rev;
    begin
      // dual type runs the two halves as independent 40-bit registers
      if (!dual && !rev) begin
        com_shift = {l[78:0], d[1]};
      end else if (!dual) begin
        com_shift = {d[3], l[79:1]};
      end else if (!rev) begin
        com_shift = {l[78:40], d[2], l[38:0], d[1]};
      end else begin
        com_shift = {d[3], l[79:41], d[2], l[39:1]};
      end
    end
  endfunction

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // match the filtered levels after reset so no false edge appears
      dsc_prev_r <= 1'b0;
      rlc_prev_r <= 1'b0;
    end else begin
      dsc_prev_r <= dsc_w;
      rlc_prev_r <= rlc_w;
    end
  end

  // segment shift register and power-down control
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seg_r <= 80'h0;
      count_r <= 7'h0;
      done_r <= 1'b0;
    end else if (rlc_w) begin
      // a high latch clock overrides any shift clock fall
      count_r <= 7'h0;
      done_r <= 1'b0;
    end else if (dsc_fall && seg_active) begin
      seg_r <= seg_shift(seg_r, din_w, is_serial, dir_w);
      // the row is full at twenty nibbles or eighty bits
      count_r <= count_r + 7'h1;
      if (count_r + 7'h1 >= fill_count) begin
        done_r <= 1'b1;
      end
    end
  end

  // output latch, or common scan shift register
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      latch_r <= 80'h0;
    end else if (rlc_fall) begin
      if (is_seg) begin
        latch_r <= seg_r;
      end else begin
        latch_r <= com_shift(latch_r, din_w, is_dual, dir_w);
      end
    end
  end

  // common scan data out towards the next driver
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dout_r <= 4'h0;
    end else begin
      dout_r <= {latch_r[79], 1'b0, latch_r[0], 1'b0};
    end
  end
  assign o_data = dout_r;
  // in the common role only the downstream end pin is driven; the other data pins, and all of them in the segment role, stay inputs
  assign o_data_oe = {~is_seg & ~dir_w, 1'b0, ~is_seg & dir_w, 1'b0};

  // enable passes downstream once this driver is full
  // both carry the same level; the output enable picks the driven pin
  assign o_enable_right_n = ~done_r;
  assign o_enable_left_n = ~done_r;
  assign o_enable_right_oe = is_seg & ~dir_w;
  assign o_enable_left_oe = is_seg & dir_w;

  // each output registers its own level code
  genvar g;
  generate
    for (g = 0; g < `OUT_COUNT; g = g + 1) begin : g_out
      reg [1:0] lvl_r;
      always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          lvl_r <= `LVL_V0;
        end else begin
          lvl_r <= level_sel(alt_w, latch_r[g], ~is_seg, blank_n_w);
        end
      end
      assign o_driver_outputs[2*g+1:2*g] = lvl_r;
    end
  endgenerate
endmodule // lcd_row_driver_shift_latch
`default_nettype wire

// file: rtl/lcd_row_driver_map.vh
// constants for the lcd row driver shift and latch logic
`ifndef LCD_ROW_DRIVER_MAP_VH
`define LCD_ROW_DRIVER_MAP_VH
`define SEG_NIBBLES 7'h14
`define SEG_BITS 7'h50
`define COM_HALF 40
`define OUT_COUNT 80
`define SYNC_WIDTH 13
`define LVL_V0 2'h0
`define LVL_V12 2'h1
`define LVL_V43 2'h2
`define LVL_V5 2'h3
`define ROLE_SEG 1'h0
`define ROLE_COM 1'h1
`define MODE_PAR_OR_SINGLE 1'h0
`define MODE_SER_OR_DUAL 1'h1
`endif

// file: rtl/pin_sync.v
// three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire i_clock,
  input wire i_reset_n,
  // asynchronous pins
  input wire [W-1:0] i_async,
  // filtered level
  output wire [W-1:0] o_level
);
  reg [W-1:0] ff1_r;
  reg [W-1:0] ff2_r;
  reg [W-1:0] ff3_r;
  reg [W-1:0] level_r;
  integer k;
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ff1_r <= {W{1'b0}};
      ff2_r <= {W{1'b0}};
      ff3_r <= {W{1'b0}};
      level_r <= {W{1'b0}};
    end else begin
      ff1_r <= i_async;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      // a change counts once the second and third stage agree
      for (k = 0; k < W; k = k + 1) begin
        if (ff2_r[k] == ff3_r[k]) begin
          level_r[k] <= ff3_r[k];
        end
      end
    end
  end
  assign o_level = level_r;
endmodule // pin_sync
`default_nettype wire

// file: tb/lcd_row_driver_checker_assertions.sv
// pin-level assertions for the lcd row driver shift and latch logic
`default_nettype none
module lcd_row_driver_checker (
  // clock and reset
  input wire i_clock,
  input wire i_reset_n,
  // controller pins
  input wire i_row_latch_clock_in,
  input wire i_frame_alternate,
  input wire i_display_blank_n,
  input wire i_role_select,
  input wire i_shift_direction,
  // driver pins
  input wire [3:0] o_data_oe,
  input wire o_enable_left_n,
  input wire o_enable_right_n,
  input wire o_enable_left_oe,
  input wire o_enable_right_oe,
  input wire [159:0] o_driver_outputs
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  wire [1:0] cs = {i_role_select, i_shift_direction};
  a_blank_v0: assert property (
    !i_display_blank_n [*8] |-> o_driver_outputs == 160'h0)
    else $error("outputs not v0 while blanked");
  a_right_oe: assert property (
    $stable(cs) [*8] |-> o_enable_right_oe == (cs == 2'h0))
    else $error("right enable oe wrong");
  a_left_oe: assert property (
    $stable(cs) [*8] |-> o_enable_left_oe == (cs == 2'h1))
    else $error("left enable oe wrong");
  a_data_oe: assert property (
    $stable(cs) [*8] |-> o_data_oe == {cs == 2'h2, 1'b0, cs == 2'h3, 1'b0})
    else $error("data oe wrong");
  a_latch_high_reinit: assert property (
    i_row_latch_clock_in [*8] |-> o_enable_right_n && o_enable_left_n)
    else $error("enable outs not reinitialised");
  a_enable_pass_pair: assert property (
    $fell(o_enable_right_n) |-> $fell(o_enable_left_n) && !i_role_select)
    else $error("enable outs differ or not segment role");
  a_level_alt_low: assert property (
    (i_display_blank_n && !i_frame_alternate) [*8] |-> o_driver_outputs[1:0] != 2'h2)
    else $error("level wrong for alternate low");
  a_level_alt_high: assert property (
    (i_display_blank_n && i_frame_alternate) [*8] |-> o_driver_outputs[1:0] != 2'h1)
    else $error("level wrong for alternate high");
  c_row_full: cover property (o_enable_right_n ##1 !o_enable_right_n);
  c_blanked: cover property (!i_display_blank_n [*8]);
  c_common: cover property (o_data_oe[3]);
endmodule // lcd_row_driver_checker
`default_nettype wire

// file: tb/lcd_ctrl_model.sv
// display controller model driving shift clock, latch clock and data pins
`default_nettype none
module lcd_ctrl_model (
  // controller pins
  output logic o_shift_clk,
  output logic o_latch_clk,
  output logic [3:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_shift_clk = 1'b1; // idle high, unused in common role
    o_latch_clk = 1'b0;
    o_data = 4'h0;
  end
  // data held four cycles either side of the fall
  task automatic shift(input logic [3:0] d);
    o_data = d;
    #160 o_shift_clk = 1'b0;
    #160 o_shift_clk = 1'b1;
  endtask
  // long high phase restarts the enable cycle
  task automatic latch(input logic [3:0] d);
    o_data = d;
    #400 o_latch_clk = 1'b1;
    #400 o_latch_clk = 1'b0;
    #240 o_data = ~d;
    #240;
  endtask
endmodule // lcd_ctrl_model
`default_nettype wire

// file: tb/lcd_row_driver_shift_latch_tb_top.sv
// self-checking bench for the lcd row driver shift and latch logic
`default_nettype none
module lcd_row_driver_shift_latch_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic alt, bl_n, role, mode, dir, el_n, er_n;
  logic [79:0] seg, lat;
  wire sck, lck, el_o, el_oe, er_o, er_oe;
  wire [3:0] din, dout, doe;
  wire [159:0] drv;
  int miscompares = 0;
  int n_compared = 0;
  always #20 i_clock = ~i_clock;
  lcd_ctrl_model lcd_ctrl_model_inst (.o_shift_clk(sck), .o_latch_clk(lck), .o_data(din));
  lcd_row_driver_shift_latch lcd_row_driver_shift_latch_inst (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_data_shift_clock_in(sck), .i_row_latch_clock_in(lck),
    .i_frame_alternate(alt), .i_display_blank_n(bl_n), .i_role_select(role),
    .i_interface_mode_select(mode), .i_shift_direction(dir), .i_data(din), .o_data(dout),
    .o_data_oe(doe), .i_enable_left_n(el_n), .o_enable_left_n(el_o), .o_enable_left_oe(el_oe),
    .i_enable_right_n(er_n), .o_enable_right_n(er_o), .o_enable_right_oe(er_oe),
    .o_driver_outputs(drv));
  task automatic check(input logic [159:0] got, input logic [159:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ctl(input logic [6:0] v);
    @(posedge i_clock);
    #1 {alt, bl_n, role, mode, dir, el_n, er_n} = v;
    repeat (8) @(posedge i_clock);
    #1;
  endtask
  function automatic logic [159:0] lv(input logic com);
    for (int k = 0; k < 80; k++)
      lv[2*k+:2] = lat[k] ? ((alt ^ com) ? 2'h3 : 2'h0) : (alt ? 2'h2 : 2'h1);
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    {alt, bl_n, role, mode, dir, el_n, er_n} = 7'h21;
    seg = '0;
    repeat (10) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    repeat (5) @(posedge i_clock);
    #1;
    for (int i = 0; i < 21; i++) begin
      lcd_ctrl_model_inst.shift(i[3:0]);
      if (i < 20) seg = {seg[75:0], i[3:0]};
    end
    #200 check(er_o, 1'b0);
    check({el_o, el_oe, er_oe}, 3'h1);
    lcd_ctrl_model_inst.latch(4'h0);
    lat = seg;
    check(drv, lv(1'b0));
    check(er_o, 1'b1);
    ctl(7'h23);
    for (int i = 0; i < 4; i++) lcd_ctrl_model_inst.shift(4'hf);
    lcd_ctrl_model_inst.latch(4'h0);
    check(drv, lv(1'b0));
    ctl(7'h03);
    ctl(7'h4e);
    check(drv, 160'h0);
    ctl(7'h6e);
    for (int i = 0; i < 80; i++) begin
      lcd_ctrl_model_inst.shift({3'h0, i[0] ^ i[2]});
      seg = {i[0] ^ i[2], seg[79:1]};
    end
    #200 check({er_o, el_o, el_oe, er_oe}, 4'h2);
    lcd_ctrl_model_inst.latch(4'h0);
    lat = seg;
    check(drv, lv(1'b0));
    ctl(7'h4e);
    check(drv, 160'h0);
    ctl(7'h13);
    ctl(7'h33);
    for (int i = 0; i < 3; i++) begin
      lcd_ctrl_model_inst.latch({2'h0, ~i[0], 1'b0});
      lat = {lat[78:0], ~i[0]};
      check(drv, lv(1'b1));
      check(dout[3], lat[79]);
      check(doe, 4'h8);
    end
    ctl(7'h13);
    ctl(7'h1b);
    ctl(7'h3b);
    lcd_ctrl_model_inst.latch(4'h6);
    lat = {lat[78:40], 1'b1, lat[38:0], 1'b1};
    check(drv, lv(1'b1));
    ctl(7'h1b);
    ctl(7'h17);
    ctl(7'h37);
    lcd_ctrl_model_inst.latch(4'h8);
    lat = {1'b1, lat[79:1]};
    check(drv, lv(1'b1));
    check({dout[1], doe}, {lat[0], 4'h2});
    tally_and_finish;
  end
endmodule // lcd_row_driver_shift_latch_tb_top
bind lcd_row_driver_shift_latch lcd_row_driver_checker lcd_row_driver_checker_inst (
  .i_clock(i_clock),
  .i_reset_n(i_reset_n),
  .i_row_latch_clock_in(i_row_latch_clock_in),
  .i_frame_alternate(i_frame_alternate),
  .i_display_blank_n(i_display_blank_n),
  .i_role_select(i_role_select),
  .i_shift_direction(i_shift_direction),
  .o_data_oe(o_data_oe),
  .o_enable_left_n(o_enable_left_n),
  .o_enable_right_n(o_enable_right_n),
  .o_enable_left_oe(o_enable_left_oe),
  .o_enable_right_oe(o_enable_right_oe),
  .o_driver_outputs(o_driver_outputs)
);
`default_nettype wire
